// File: rtl/dskc_pkg.sv
// Overview of operation
// - status port A reports drive signal levels
// - status port B reports selects and synchronised line levels
// - output control register clears on reset
// - motor enables, dma gate, controller reset bit
// - two bits pick drive zero to three
// - input sense read shows change and config
// - config write sets precomp and rate bits
// - main status readable anytime without side effect
// - request bit set when data port ready
// - direction bit one when controller presents bytes
// - non-dma and busy bits, two reserved
// - seek busy bits for drives zero and one only
// - data port steps through internal byte stack
// - command, execution, result phases in turn
// - address bit zero picks status or data
// - fifteen commands are recognised
// - specify sets head settle and release times
// - four-bit step interval sets step spacing
// - density and both-heads bits decoded
// - byte length used only when size zero
// - scan step one or two sectors
// - unit select bits match output control encoding
// - unknown command returns single invalid status
package dskc_pkg;
  localparam logic [9:0] ADDR_STAT_A = 10'h3F0;
  localparam logic [9:0] ADDR_STAT_B = 10'h3F1;
  localparam logic [9:0] ADDR_OUT_CTRL = 10'h3F2;
  localparam logic [9:0] ADDR_MAIN_STAT = 10'h3F4;
  localparam logic [9:0] ADDR_DATA = 10'h3F5;
  localparam logic [9:0] ADDR_SENSE_CFG = 10'h3F7;
  localparam logic [7:0] OUT_CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_MASK = 8'h06;
  localparam int OC_DMA_BIT = 3;
  localparam int OC_NRST_BIT = 2;
  localparam int MS_RQM = 7;
  localparam int MS_DIO = 6;
  localparam int MS_NDMA = 5;
  localparam int MS_BUSY = 4;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam int MS_PER_STEP_NS = 1000000;
  localparam int CLK_NS = 10;
  localparam int CYC_PER_MS = MS_PER_STEP_NS / CLK_NS;
  localparam int EXEC_CYCLES = 16;
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0C;
  localparam logic [4:0] OP_READ_TRK = 5'h02;
  localparam logic [4:0] OP_READ_ID = 5'h0A;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] OP_FORMAT = 5'h0D;
  localparam logic [4:0] OP_SCAN_EQ = 5'h11;
  localparam logic [4:0] OP_SCAN_LE = 5'h19;
  localparam logic [4:0] OP_SCAN_HE = 5'h1D;
  localparam logic [4:0] OP_RECAL = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SENSE_DRV = 5'h04;
  localparam logic [4:0] OP_SEEK = 5'h0F;
  typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} phase_t;
endpackage : dskc_pkg

// File: rtl/dskc_host_port.sv
module dskc_host_port
  import dskc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [9:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic irq_req_i,
  input wire logic dma_req_i,
  input wire logic step_i,
  input wire logic track0_i,
  input wire logic head1_sel_n_i,
  input wire logic index_i,
  input wire logic wprot_i,
  input wire logic dir_n_i,
  input wire logic wr_data_i,
  input wire logic rd_data_i,
  input wire logic wr_en_i,
  input wire logic disk_change_n_i,
  output logic [3:0] motor_en_o,
  output logic [3:0] drive_sel_n_o,
  output logic dma_irq_gate_o,
  output logic irq_o,
  output logic dma_req_o,
  output logic no_precomp_o,
  output logic rate_250k_o,
  output logic density_select_o,
  output logic both_heads_flag_o,
  output logic head_select_o,
  output logic [7:0] step_interval_ms_o,
  output logic [8:0] head_settle_time_o,
  output logic [7:0] head_release_time_o
);
  // pin synchronisers: stage one read only by stage two
  logic [13:0] pin_s1_r, pin_s2_r;
  logic [7:0] out_ctrl_r, cfg_r;
  phase_t phase_r, phase_nxt;
  logic [3:0] cnt_r;
  logic [3:0] need_r;
  logic [4:0] op_r;
  logic [7:0] bytes_r [0:8];
  logic [7:0] res_r [0:6];
  logic [2:0] res_len_r;
  logic [1:0] seek_busy_r;
  logic [7:0] cyl_r [0:1];
  logic [7:0] last_st0_r;
  logic [3:0] step_code_r;
  logic [6:0] hlt_r;
  logic [3:0] hut_r;
  logic no_dma_transfer_mode_r;
  logic [4:0] exec_cnt_r;
  logic [7:0] rdata_r;
  logic rw_cmd_r;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else if (clk_en_i) begin
      pin_s1_r <= {disk_change_n_i, wr_en_i, rd_data_i, wr_data_i, dir_n_i,
                   wprot_i, index_i, head1_sel_n_i, track0_i, step_i,
                   dma_req_i, irq_req_i, 2'b00};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire [7:0] port_a = {pin_s2_r[2], pin_s2_r[3], pin_s2_r[4], pin_s2_r[5],
                       pin_s2_r[6], pin_s2_r[7], pin_s2_r[8],
                       pin_s2_r[9]};
  // drive selects are decoded from the output control register
  wire [3:0] sel_n = ~(4'h1 << out_ctrl_r[1:0]);
  wire [7:0] port_b = {1'b0, sel_n[1], sel_n[0], pin_s2_r[10],
                       pin_s2_r[11], pin_s2_r[12], sel_n[3],
                       sel_n[2]};
  wire [7:0] sense_in = {pin_s2_r[13], 3'b000, out_ctrl_r[OC_DMA_BIT],
                         cfg_r[2], cfg_r[1], 1'b0};
  wire ctrl_run = out_ctrl_r[OC_NRST_BIT];
  wire rqm = ctrl_run && (phase_r != PH_EXEC);
  wire dio = (phase_r == PH_RES);
  wire busy = (phase_r == PH_EXEC) && rw_cmd_r;
  wire [7:0] main_stat = {rqm, dio, no_dma_transfer_mode_r, busy, 2'b00,
                          seek_busy_r};
  wire data_sel = (addr_i == ADDR_DATA);
  wire data_wr = wr_i && data_sel && ctrl_run && phase_r == PH_CMD;
  wire data_rd = rd_i && data_sel && ctrl_run && phase_r == PH_RES;
  wire [4:0] first_op = wdata_i[4:0];

  // parameter bytes expected after the command byte, all ones if unknown
  function automatic logic [3:0] param_count(input logic [4:0] op,
                                             input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    case (op)
      OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL, OP_SCAN_EQ, OP_SCAN_LE,
      OP_SCAN_HE: n = 4'h8;
      OP_READ_TRK: n = (b[7] == 1'b0) ? 4'h8 : 4'h0;
      OP_READ_ID, OP_RECAL, OP_SENSE_DRV: n = 4'h1;
      OP_FORMAT: n = 4'h5;
      OP_SEEK, OP_SPECIFY: n = 4'h2;
      OP_SENSE_INT: n = 4'h0;
      default: n = 4'hF;
    endcase
    return n;
  endfunction : param_count

  wire [3:0] first_need = param_count(first_op, wdata_i);
  wire cmd_done = data_wr && ((cnt_r == 4'h0) ? (first_need == 4'h0 ||
                  first_need == 4'hF) : (cnt_r == need_r));
  wire last_res = data_rd && ({1'b0, cnt_r} == {1'b0, res_len_r} - 5'd1);

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_CMD: if (cmd_done) phase_nxt = PH_EXEC;
      PH_EXEC: if (exec_cnt_r == 5'd0) phase_nxt = PH_RES;
      PH_RES: if (last_res || res_len_r == 3'd0) phase_nxt = PH_CMD;
      default: phase_nxt = PH_CMD;
    endcase
  end

  // sector size code zero means the byte-length parameter counts
  wire [7:0] sec_len = bytes_r[5][7:0];
  wire [7:0] xfer_len = (sec_len == 8'h00) ? bytes_r[8] : 8'hFF;
  wire scan_alt = (bytes_r[8] == 8'h02);
  wire [1:0] unit = bytes_r[1][1:0];
  // the unit byte may still be on the bus when a one-parameter command ends
  wire [4:0] cur_op = (cnt_r == 4'h0) ? first_op : op_r;
  wire [1:0] cur_unit = (cnt_r == 4'h1) ? wdata_i[1:0] : unit;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_ctrl_r <= OUT_CTRL_RST;
      cfg_r <= 8'h00;
    end else if (clk_en_i && wr_i) begin
      if (addr_i == ADDR_OUT_CTRL) out_ctrl_r <= wdata_i;
      if (addr_i == ADDR_SENSE_CFG) cfg_r <= wdata_i & CFG_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_r <= PH_CMD;
      cnt_r <= 4'h0;
      need_r <= 4'h0;
      op_r <= 5'h00;
      res_len_r <= 3'd0;
      exec_cnt_r <= 5'd0;
      rw_cmd_r <= 1'b0;
      seek_busy_r <= 2'b00;
      last_st0_r <= 8'h00;
      step_code_r <= 4'h0;
      hlt_r <= 7'h00;
      hut_r <= 4'h0;
      no_dma_transfer_mode_r <= 1'b0;
      cyl_r[0] <= 8'h00;
      cyl_r[1] <= 8'h00;
      for (int i = 0; i < 9; i++) bytes_r[i] <= 8'h00;
      for (int i = 0; i < 7; i++) res_r[i] <= 8'h00;
    end else if (clk_en_i) begin
      if (!ctrl_run) begin
        phase_r <= PH_CMD;
        cnt_r <= 4'h0;
        seek_busy_r <= 2'b00;
        rw_cmd_r <= 1'b0;
      end else begin
        phase_r <= phase_nxt;
        if (data_wr) begin
          bytes_r[cnt_r] <= wdata_i;
          if (cnt_r == 4'h0) begin
            op_r <= first_op;
            need_r <= first_need;
            rw_cmd_r <= first_need == 4'h8 || first_op == OP_FORMAT;
          end
          cnt_r <= cmd_done ? 4'h0 : cnt_r + 4'h1;
          if (cmd_done) exec_cnt_r <= 5'(EXEC_CYCLES);
          if (cmd_done && cnt_r == 4'h0 && first_need == 4'hF) begin
            res_r[0] <= ST0_INVALID;
            res_len_r <= 3'd1;
            exec_cnt_r <= 5'd0;
          end
        end
        if (phase_r == PH_EXEC) begin
          if (exec_cnt_r != 5'd0) exec_cnt_r <= exec_cnt_r - 5'd1;
          else if (need_r != 4'hF) begin
            seek_busy_r <= 2'b00;
            case (op_r)
              OP_SPECIFY: begin
                step_code_r <= bytes_r[1][7:4];
                hut_r <= bytes_r[1][3:0];
                hlt_r <= bytes_r[2][7:1];
                no_dma_transfer_mode_r <= bytes_r[2][0];
                res_len_r <= 3'd0;
              end
              OP_SEEK, OP_RECAL: begin
                if (!unit[1])
                  cyl_r[unit[0]] <= (op_r == OP_SEEK) ? bytes_r[2] : 8'h00;
                last_st0_r <= ST0_SEEK_END | {5'b0, bytes_r[1][2:0]};
                res_len_r <= 3'd0;
              end
              OP_SENSE_INT: begin
                res_r[0] <= last_st0_r;
                res_r[1] <= cyl_r[last_st0_r[0]];
                res_len_r <= 3'd2;
              end
              OP_SENSE_DRV: begin
                res_r[0] <= {1'b0, pin_s2_r[8], 1'b1, pin_s2_r[5], 1'b1,
                             bytes_r[1][2:0]};
                res_len_r <= 3'd1;
              end
              default: begin
                res_r[0] <= {5'b0, bytes_r[1][2:0]};
                res_r[1] <= 8'h00;
                res_r[2] <= {7'b0, scan_alt};
                res_r[3] <= bytes_r[2];
                res_r[4] <= bytes_r[3];
                res_r[5] <= bytes_r[4];
                res_r[6] <= xfer_len;
                res_len_r <= 3'd7;
              end
            endcase
          end
        end else if (phase_r == PH_CMD && cmd_done && !cur_unit[1] &&
                     (cur_op == OP_SEEK || cur_op == OP_RECAL)) begin
          seek_busy_r[cur_unit[0]] <= 1'b1;
        end
        if (data_rd) cnt_r <= last_res ? 4'h0 : cnt_r + 4'h1;
        if (last_res) rw_cmd_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rdata_r <= 8'h00;
    else if (clk_en_i && rd_i) begin
      case (addr_i)
        ADDR_STAT_A: rdata_r <= port_a;
        ADDR_STAT_B: rdata_r <= port_b;
        ADDR_MAIN_STAT: rdata_r <= main_stat;
        ADDR_DATA: rdata_r <= data_rd ? res_r[cnt_r[2:0]] : 8'h00;
        ADDR_SENSE_CFG: rdata_r <= sense_in;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      motor_en_o <= 4'h0;
      drive_sel_n_o <= 4'hF;
      dma_irq_gate_o <= 1'b0;
      irq_o <= 1'b0;
      dma_req_o <= 1'b0;
      no_precomp_o <= 1'b0;
      rate_250k_o <= 1'b0;
      density_select_o <= 1'b0;
      both_heads_flag_o <= 1'b0;
      head_select_o <= 1'b0;
      step_interval_ms_o <= 8'h00;
      head_settle_time_o <= 9'h000;
      head_release_time_o <= 8'h00;
    end else if (clk_en_i) begin
      motor_en_o <= out_ctrl_r[7:4];
      drive_sel_n_o <= sel_n;
      dma_irq_gate_o <= out_ctrl_r[OC_DMA_BIT];
      irq_o <= out_ctrl_r[OC_DMA_BIT] && pin_s2_r[2];
      dma_req_o <= out_ctrl_r[OC_DMA_BIT] && pin_s2_r[3];
      no_precomp_o <= cfg_r[2];
      rate_250k_o <= cfg_r[1];
      density_select_o <= bytes_r[0][6];
      both_heads_flag_o <= bytes_r[0][7];
      head_select_o <= bytes_r[1][2];
      step_interval_ms_o <= {4'h0, 4'hF - step_code_r} + 8'h01;
      head_settle_time_o <= {1'b0, hlt_r, 1'b0} + 9'h002;
      head_release_time_o <= {hut_r, 4'h0};
    end
  end

  assign rdata_o = rdata_r;
endmodule : dskc_host_port

// File: tb/drive_model.sv
module drive_model (
  input wire logic [3:0] drive_sel_n_i,
  input wire logic [3:0] motor_en_i,
  output logic [11:0] pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic spin;
  logic unit0;
  // lines follow whether any selected drive has its motor running, or whether drive zero is selected
  assign spin = |(motor_en_i & ~drive_sel_n_i);
  assign unit0 = ~drive_sel_n_i[0];
  assign pins_o = {spin, unit0, spin, unit0, ~spin, spin, unit0, ~spin,
                   spin, unit0, spin, ~unit0};
endmodule : drive_model

// File: tb/dskc_host_port_checker.sv
module dskc_host_port_checker
  import dskc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [9:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] motor_en_o,
  input wire logic [3:0] drive_sel_n_o,
  input wire logic dma_irq_gate_o,
  input wire logic irq_o,
  input wire logic dma_req_o,
  input wire logic no_precomp_o,
  input wire logic rate_250k_o
);
  logic [7:0] oc_r;
  logic [7:0] cw_r;
  logic oc_wr;
  logic cw_wr;
  logic rd_ms;
  logic rd_dp;
  assign oc_wr = clk_en_i && wr_i && addr_i == ADDR_OUT_CTRL;
  assign cw_wr = clk_en_i && wr_i && addr_i == ADDR_SENSE_CFG;
  assign rd_ms = clk_en_i && rd_i && addr_i == ADDR_MAIN_STAT;
  assign rd_dp = clk_en_i && rd_i && addr_i == ADDR_DATA;
  // shadow copies, since neither register reads back whole at the pins (input sense shows only the dma bit and two config bits)
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oc_r <= OUT_CTRL_RST;
      cw_r <= 8'h00;
    end else begin
      if (oc_wr) oc_r <= wdata_i;
      if (cw_wr) cw_r <= wdata_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_reset_clears_out: assert property (
    $fell(sys_rst_i) |-> motor_en_o == 4'h0 && !dma_irq_gate_o)
    else $error("output control not clear after reset");
  chk_motor_follow: assert property (
    oc_wr |-> ##2 motor_en_o == oc_r[7:4])
    else $error("motor enables differ from written value");
  chk_drive_decode: assert property (
    oc_wr |-> ##2 drive_sel_n_o == ~(4'h1 << oc_r[1:0]))
    else $error("drive select decode wrong");
  chk_gate_follow: assert property (
    oc_wr |-> ##2 dma_irq_gate_o == oc_r[OC_DMA_BIT])
    else $error("dma and interrupt gate wrong");
  chk_req_masked: assert property (
    !dma_irq_gate_o && !$past(dma_irq_gate_o) |-> !irq_o && !dma_req_o)
    else $error("request passed while gate closed");
  chk_cfg_follow: assert property (
    cw_wr |-> ##2 {no_precomp_o, rate_250k_o} == cw_r[2:1])
    else $error("config outputs differ from written value");
  chk_held_quiet: assert property (
    rd_dp && !oc_r[OC_NRST_BIT] |-> ##1 rdata_o == 8'h00)
    else $error("data port answered while controller held");
  chk_msr_reserved: assert property (
    rd_ms |-> ##1 rdata_o[3:2] == 2'b00)
    else $error("main status reserved bits set");
  chk_rdata_stands: assert property (
    !rd_i |=> $stable(rdata_o))
    else $error("read data changed without a read");
  cover property (oc_wr && wdata_i[OC_NRST_BIT]);
  cover property (rd_dp && oc_r[OC_NRST_BIT]);
  cover property (cw_wr);
endmodule : dskc_host_port_checker

bind dskc_host_port dskc_host_port_checker u_chk (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .addr_i(addr_i), .rd_i(rd_i),
  .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .motor_en_o(motor_en_o), .drive_sel_n_o(drive_sel_n_o),
  .dma_irq_gate_o(dma_irq_gate_o), .irq_o(irq_o), .dma_req_o(dma_req_o),
  .no_precomp_o(no_precomp_o), .rate_250k_o(rate_250k_o));

// File: tb/diskette_controller_host_port_test.sv
module diskette_controller_host_port_test
  import dskc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00, rdata, got, stepms, hrel;
  logic [8:0] hset;
  logic [11:0] pins;
  logic [3:0] motor, dsel_n;
  logic dens;
  int num_errors = 0, compares = 0, cycles = 0;
  // dor, cfg, port a, port b, input sense
  logic [7:0] tab [2][5] = '{'{8'h1C, 8'h06, 8'hF6, 8'h5F, 8'h0E},
                             '{8'h0D, 8'h02, 8'h09, 8'h23, 8'h8A}};
  logic [7:0] rdprm [8] = '{8'h00, 8'h02, 8'h00, 8'h03, 8'h02, 8'h09,
                            8'h1B, 8'hFF};
  dskc_host_port DUT (.sys_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1),
    .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
    .irq_req_i(pins[11]), .dma_req_i(pins[10]), .step_i(pins[9]),
    .track0_i(pins[8]), .head1_sel_n_i(pins[7]), .index_i(pins[6]),
    .wprot_i(pins[5]), .dir_n_i(pins[4]), .wr_data_i(pins[3]),
    .rd_data_i(pins[2]), .wr_en_i(pins[1]), .disk_change_n_i(pins[0]),
    .motor_en_o(motor), .drive_sel_n_o(dsel_n), .dma_irq_gate_o(),
    .irq_o(), .dma_req_o(), .no_precomp_o(), .rate_250k_o(),
    .density_select_o(dens), .both_heads_flag_o(), .head_select_o(),
    .step_interval_ms_o(stepms), .head_settle_time_o(hset),
    .head_release_time_o(hrel));
  drive_model u_drv (.drive_sel_n_i(dsel_n), .motor_en_i(motor),
    .pins_o(pins));
  initial begin
    forever #5 clk = ~clk;
  end
  task print_verdict();
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task chk(input string name, input logic [8:0] exp, input logic [8:0] seen);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {addr, wdata, wr} = {a, d, 1'b1};
    @(posedge clk);
    #1 wr = 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 {addr, rd} = {a, 1'b1};
    @(posedge clk);
    #1 rd = 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask : rd_reg
  // polling is bounded so a stuck request bit ends in a mismatch
  task wait_rqm();
    logic [7:0] s;
    int n;
    s = 8'h00;
    for (n = 0; n < 200 && s[7] !== 1'b1; n++) rd_reg(ADDR_MAIN_STAT, s);
    chk("rqm", 9'h001, {8'h00, s[7]});
  endtask : wait_rqm
  task put(input logic [7:0] d);
    wait_rqm();
    wr_reg(ADDR_DATA, d);
  endtask : put
  task get(output logic [7:0] d);
    wait_rqm();
    rd_reg(ADDR_DATA, d);
  endtask : get
  task msr(input string name, input logic [7:0] mask, input logic [7:0] e);
    rd_reg(ADDR_MAIN_STAT, got);
    chk(name, {1'b0, e}, {1'b0, got & mask});
  endtask : msr
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    chk("motor_rst", 9'h000, {5'h00, motor});
    rd_reg(ADDR_DATA, got);
    chk("held", 9'h000, {1'b0, got});
    for (int i = 0; i < 2; i++) begin
      wr_reg(ADDR_OUT_CTRL, tab[i][0]);
      wr_reg(ADDR_SENSE_CFG, tab[i][1]);
      repeat (4) @(posedge clk);
      chk("motor", {5'h00, tab[i][0][7:4]}, {5'h00, motor});
      chk("dsel", {5'h00, ~(4'h1 << tab[i][0][1:0])}, {5'h00, dsel_n});
      for (int k = 0; k < 3; k++) begin
        rd_reg(k == 2 ? ADDR_SENSE_CFG : ADDR_STAT_A + 10'(k), got);
        chk("port", {1'b0, tab[i][k + 2]}, {1'b0, got});
      end
    end
    rd_reg(10'h3F3, got);
    chk("unmapped", 9'h000, {1'b0, got});
    msr("msr_idle", 8'hFF, 8'h80);
    for (int i = 0; i < 3; i++) begin
      put(8'h03);
      put({4'(15 - i), 4'h3});
      put(8'h0B);
      wait_rqm();
      chk("step", 9'(i + 1), {1'b0, stepms});
    end
    chk("release", 9'd48, {1'b0, hrel});
    chk("settle", 9'd12, hset);
    msr("msr_nodma", 8'hFF, 8'hA0);
    put(8'h0F);
    put(8'h01);
    put(8'h05);
    msr("seek_busy", 8'h83, 8'h02);
    put(8'h08);
    get(got);
    chk("st0", 9'h021, {1'b0, got});
    get(got);
    chk("cyl", 9'h005, {1'b0, got});
    msr("msr_back", 8'hD0, 8'h80);
    put(8'h00);
    get(got);
    chk("invalid", {1'b0, ST0_INVALID}, {1'b0, got});
    msr("msr_inv", 8'hD0, 8'h80);
    put(8'h46);
    for (int k = 0; k < 8; k++) put(rdprm[k]);
    msr("rw_busy", 8'h10, 8'h10);
    for (int k = 0; k < 7; k++) get(got);
    chk("density", 9'h001, {8'h00, dens});
    msr("msr_rw_end", 8'hD0, 8'h80);
    wr_reg(ADDR_OUT_CTRL, 8'h08);
    repeat (4) @(posedge clk);
    wr_reg(ADDR_DATA, 8'h08);
    rd_reg(ADDR_DATA, got);
    chk("held_mid", 9'h000, {1'b0, got});
    wr_reg(ADDR_OUT_CTRL, 8'h0C);
    repeat (4) @(posedge clk);
    msr("msr_abort", 8'hD0, 8'h80);
    print_verdict();
  end
endmodule : diskette_controller_host_port_test
